// ==== vps_vcxo_sysref_ctrl.sv ====
// top: registers, vcxo-pll controls and counted sysref burst generator
// Operation
// - pump current equals six-bit code times 20 uA, reset code 32.
// - polarity bit 0 drives vcxo control positive, 1 inverted; reset 0.
// - holdover bit 1 parks vcxo control at mid-supply; 0 normal.
// - bypass bit 1 routes around the vcxo-pll; 0 keeps it in path.
// - eight-bit burst length resets zero; a nonzero write in idle, with output mode bit clear and synchronizer on, launches 1 to 255 pulses.
// - burst waits until sysref synchronization has completed.
// - burst appears together on every enabled reference output whose source select is 1.
// - burst length is a straight binary pulse count.
// - pulses released only on synchronizer-divider coincident edges.
// - synchronizer powered when its power-down bit is 0, off when 1.
// - source select 1 takes sysref path, 0 takes clock divider.
`timescale 1ns/1ps
module vps_vcxo_sysref_ctrl #(
    parameter int NUM_REF = vps_pkg::NUM_REF
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    input wire logic [NUM_REF-1:0] reference_source_select,
    input wire logic [NUM_REF-1:0] clock_div_in,
    output logic [NUM_REF-1:0] reference_output,
    output logic [5:0] pump_current_code,
    output logic [10:0] pump_current_ua,
    output logic vcxo_polarity_select,
    output logic holdover,
    output logic vcxo_mid_supply,
    output logic vcxo_bypass,
    output logic synchronizer_power_down,
    output logic burst_active
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] vco_mode_reg, sync_div_reg, sref_div_oe_reg, loop_ctrl_reg;
    logic [7:0] bypass_dly_reg, burst_len_reg;
    logic burst_start;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            vco_mode_reg <= vps_pkg::RST_VCO_DIV_MODE;
            sync_div_reg <= vps_pkg::RST_SYNC_DIV;
            sref_div_oe_reg <= vps_pkg::RST_SREF_DIV_OE;
            loop_ctrl_reg <= vps_pkg::RST_LOOP_CTRL;
            bypass_dly_reg <= vps_pkg::RST_BYPASS_DLY;
            burst_len_reg <= vps_pkg::RST_BURST_LEN;
        end else if (cfg_wr) begin
            unique case (cfg_addr)
                vps_pkg::ADDR_VCO_DIV_MODE: vco_mode_reg <= cfg_wdata;
                vps_pkg::ADDR_SYNC_DIV: sync_div_reg <= cfg_wdata;
                vps_pkg::ADDR_SREF_DIV_OE: sref_div_oe_reg <= cfg_wdata;
                vps_pkg::ADDR_LOOP_CTRL: loop_ctrl_reg <= cfg_wdata;
                vps_pkg::ADDR_BYPASS_DLY: bypass_dly_reg <=
                    (cfg_wdata & vps_pkg::BYPASS_RW_MASK) | vps_pkg::BYPASS_FIXED;
                vps_pkg::ADDR_BURST_LEN: burst_len_reg <= cfg_wdata;
                default: ;
            endcase
        end
    end

    logic [7:0] rdata_next;
    always_comb begin
        unique case (cfg_addr)
            vps_pkg::ADDR_VCO_DIV_MODE: rdata_next = vco_mode_reg;
            vps_pkg::ADDR_SYNC_DIV: rdata_next = sync_div_reg;
            vps_pkg::ADDR_SREF_DIV_OE: rdata_next = sref_div_oe_reg;
            vps_pkg::ADDR_LOOP_CTRL: rdata_next = loop_ctrl_reg;
            vps_pkg::ADDR_BYPASS_DLY: rdata_next = bypass_dly_reg;
            vps_pkg::ADDR_BURST_LEN: rdata_next = burst_len_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_rd) begin
            cfg_rdata <= rdata_next;
        end
    end

    // ************************************************************
    // vcxo-pll controls
    // ************************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pump_current_code <= vps_pkg::RST_LOOP_CTRL[5:0];
            pump_current_ua <= 11'(vps_pkg::RST_LOOP_CTRL[5:0] * vps_pkg::PUMP_STEP_UA);
            vcxo_polarity_select <= 1'b0;
            holdover <= 1'b0;
            vcxo_mid_supply <= 1'b0;
            vcxo_bypass <= 1'b0;
            synchronizer_power_down <= 1'b0;
        end else begin
            pump_current_code <= loop_ctrl_reg[5:0];
            pump_current_ua <= 11'(loop_ctrl_reg[5:0] * vps_pkg::PUMP_STEP_UA);
            vcxo_polarity_select <= loop_ctrl_reg[vps_pkg::POS_POLARITY];
            holdover <= loop_ctrl_reg[vps_pkg::POS_HOLD];
            vcxo_mid_supply <= loop_ctrl_reg[vps_pkg::POS_HOLD];
            vcxo_bypass <= bypass_dly_reg[vps_pkg::POS_BYPASS];
            synchronizer_power_down <= sync_div_reg[vps_pkg::POS_SYNC_PD];
        end
    end

    // ************************************************************
    // burst generator
    // ************************************************************
    // counted bursts only when the output mode bit is clear
    assign burst_start = cfg_wr && (cfg_addr == vps_pkg::ADDR_BURST_LEN)
        && (cfg_wdata != 8'h00) && !vco_mode_reg[vps_pkg::POS_OUTPUT_MODE];

    vps_pkg::vps_state_t state_reg;
    logic [3:0] sync_cnt_reg;
    logic [11:0] div_cnt_reg, div_ratio;
    logic [7:0] pulses_left_reg;
    logic sysref_pulse_reg, coincident;

    assign div_ratio = vps_pkg::vps_div_ratio(sref_div_oe_reg[7:vps_pkg::POS_DIV_SEL_LO]);
    // release point: divider wraps, standing in for coincident divided edges
    assign coincident = (div_cnt_reg == 12'h000);
    assign burst_active = (state_reg != vps_pkg::VPS_IDLE);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_reg <= 12'h000;
        end else if (div_cnt_reg >= div_ratio - 12'h001) begin
            div_cnt_reg <= 12'h000;
        end else begin
            div_cnt_reg <= div_cnt_reg + 12'h001;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= vps_pkg::VPS_IDLE;
            sync_cnt_reg <= 4'h0;
            pulses_left_reg <= 8'h00;
            sysref_pulse_reg <= 1'b0;
        end else begin
            sysref_pulse_reg <= 1'b0;
            unique case (state_reg)
                vps_pkg::VPS_IDLE: begin
                    if (burst_start && !synchronizer_power_down) begin
                        state_reg <= vps_pkg::VPS_SYNC;
                        sync_cnt_reg <= vps_pkg::SYNC_CYCLES;
                        pulses_left_reg <= cfg_wdata;
                    end
                end
                vps_pkg::VPS_SYNC: begin
                    if (synchronizer_power_down) begin
                        state_reg <= vps_pkg::VPS_IDLE;
                    end else if (sync_cnt_reg == 4'h0) begin
                        state_reg <= vps_pkg::VPS_BURST;
                    end else begin
                        sync_cnt_reg <= sync_cnt_reg - 4'h1;
                    end
                end
                vps_pkg::VPS_BURST: begin
                    if (coincident) begin
                        sysref_pulse_reg <= 1'b1;
                        pulses_left_reg <= pulses_left_reg - 8'h01;
                        if (pulses_left_reg == 8'h01) begin
                            state_reg <= vps_pkg::VPS_IDLE;
                        end
                    end
                end
                default: state_reg <= vps_pkg::VPS_IDLE;
            endcase
        end
    end

    // ************************************************************
    // reference outputs
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REF; gi++) begin : g_ref
            vps_ref_out u_ref (
                .clock(clock),
                .rst_b(rst_b),
                .enable(sref_div_oe_reg[gi]),
                .source_sel(reference_source_select[gi]),
                .sysref_pulse(sysref_pulse_reg),
                .clock_div_in(clock_div_in[gi]),
                .reference_output(reference_output[gi])
            );
        end
    endgenerate

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_launch;
        burst_start && !synchronizer_power_down && state_reg == vps_pkg::VPS_IDLE;
    endsequence

    property p_pump;
        @(posedge clock) disable iff (!rst_b)
        pump_current_ua == 11'(pump_current_code * 20);
    endproperty
    a_pump: assert property (p_pump) else $error("pump current mismatch");

    property p_pol;
        @(posedge clock) disable iff (!rst_b)
        1'b1 |=> vcxo_polarity_select == $past(loop_ctrl_reg[7]);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity not following");

    property p_hold;
        @(posedge clock) disable iff (!rst_b)
        vcxo_mid_supply == holdover;
    endproperty
    a_hold: assert property (p_hold) else $error("holdover mid-supply mismatch");

    property p_bypass;
        @(posedge clock) disable iff (!rst_b)
        1'b1 |=> vcxo_bypass == $past(bypass_dly_reg[4]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not following");

    property p_hold_off;
        @(posedge clock) disable iff (!rst_b)
        s_launch |=> !sysref_pulse_reg [*8];
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("pulse before sync");

    property p_mode_one;
        @(posedge clock) disable iff (!rst_b)
        cfg_wr && cfg_addr == vps_pkg::ADDR_BURST_LEN && vco_mode_reg[0]
            && state_reg == vps_pkg::VPS_IDLE |=> state_reg == vps_pkg::VPS_IDLE;
    endproperty
    a_mode_one: assert property (p_mode_one) else $error("burst started in mode one");

    property p_coinc;
        @(posedge clock) disable iff (!rst_b)
        sysref_pulse_reg |-> $past(coincident);
    endproperty
    a_coinc: assert property (p_coinc) else $error("pulse off coincidence");

    property p_count;
        @(posedge clock) disable iff (!rst_b)
        sysref_pulse_reg |->
            (state_reg == vps_pkg::VPS_IDLE) == ($past(pulses_left_reg) == 8'h01);
    endproperty
    a_count: assert property (p_count) else $error("extra pulse");

    property p_sync_pd;
        @(posedge clock) disable iff (!rst_b)
        synchronizer_power_down |-> ##1 state_reg != vps_pkg::VPS_BURST
            || $past(state_reg) == vps_pkg::VPS_BURST;
    endproperty
    a_sync_pd: assert property (p_sync_pd) else $error("burst with sync off");
endmodule : vps_vcxo_sysref_ctrl

// ==== vps_pkg.sv ====
// package: register map, field positions, reset values and divider table for vcxo/sysref control
package vps_pkg;
    localparam logic [7:0] ADDR_VCO_DIV_MODE = 8'h03;
    localparam logic [7:0] ADDR_SYNC_DIV = 8'h07;
    localparam logic [7:0] ADDR_SREF_DIV_OE = 8'h0b;
    localparam logic [7:0] ADDR_LOOP_CTRL = 8'h0d;
    localparam logic [7:0] ADDR_BYPASS_DLY = 8'h10;
    localparam logic [7:0] ADDR_BURST_LEN = 8'h17;

    localparam logic [7:0] RST_VCO_DIV_MODE = 8'h00;
    localparam logic [7:0] RST_SYNC_DIV = 8'h04;
    localparam logic [7:0] RST_SREF_DIV_OE = 8'h4f;
    localparam logic [7:0] RST_LOOP_CTRL = 8'h20;
    localparam logic [7:0] RST_BYPASS_DLY = 8'h04;
    localparam logic [7:0] RST_BURST_LEN = 8'h00;

    // low four bits of the bypass register are fixed and read back as 0100
    localparam logic [7:0] BYPASS_RW_MASK = 8'hf0;
    localparam logic [7:0] BYPASS_FIXED = 8'h04;

    localparam int POS_OUTPUT_MODE = 0;
    localparam int POS_SYNC_PD = 5;
    localparam int POS_HOLD = 6;
    localparam int POS_POLARITY = 7;
    localparam int POS_BYPASS = 4;
    localparam int POS_DIV_SEL_LO = 4;

    localparam int PUMP_STEP_UA = 20;
    localparam int NUM_REF = 4;

    // sync countdown start; the sync state lasts this many clock cycles plus one
    localparam logic [3:0] SYNC_CYCLES = 4'h8;

    typedef enum logic [1:0] {
        VPS_IDLE = 2'b00,
        VPS_SYNC = 2'b01,
        VPS_BURST = 2'b10
    } vps_state_t;

    // divide ratio per select code; undefined codes fall back to 64
    function automatic logic [11:0] vps_div_ratio(input logic [3:0] sel);
        unique case (sel)
            4'h0: vps_div_ratio = 12'h040;
            4'h1: vps_div_ratio = 12'h060;
            4'h2: vps_div_ratio = 12'h080;
            4'h3: vps_div_ratio = 12'h0c0;
            4'h4: vps_div_ratio = 12'h100;
            4'h5: vps_div_ratio = 12'h180;
            4'h6: vps_div_ratio = 12'h200;
            4'h7: vps_div_ratio = 12'h300;
            4'h8: vps_div_ratio = 12'h400;
            4'h9: vps_div_ratio = 12'h800;
            default: vps_div_ratio = 12'h040;
        endcase
    endfunction : vps_div_ratio
endpackage : vps_pkg

// ==== vps_ref_out.sv ====
// one reference output: source select and enable gating
`timescale 1ns/1ps
module vps_ref_out (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic source_sel,
    input wire logic sysref_pulse,
    input wire logic clock_div_in,
    output logic reference_output
);
    // disabled output parks low, the documented inactive state
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reference_output <= 1'b0;
        end else begin
            reference_output <= enable & (source_sel ? sysref_pulse : clock_div_in);
        end
    end
endmodule : vps_ref_out

// ==== vps_host.sv ====
// host model: drives the configuration strobes the way a controller does
`timescale 1ns/1ps
module vps_host (
    input wire logic clock,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata
);
    logic [7:0] mode_reg;
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
        mode_reg = vps_pkg::RST_VCO_DIV_MODE;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        if (a == vps_pkg::ADDR_VCO_DIV_MODE) mode_reg = d;
        @(posedge clock);
        cfg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clock);
        cfg_rd <= 1'b0;
        #1;
        d = cfg_rdata;
    endtask : rd
    // output mode bit is cleared first, else the count write launches nothing
    task automatic burst(input logic [7:0] n);
        wr(vps_pkg::ADDR_VCO_DIV_MODE, mode_reg & 8'hfe);
        wr(vps_pkg::ADDR_BURST_LEN, n);
    endtask : burst
endmodule : vps_host

// ==== vcxo_pll_and_sysref_control_tb_top.sv ====
// testbench: register model, vcxo controls and counted sysref bursts
`timescale 1ns/1ps
module vcxo_pll_and_sysref_control_tb_top;
    logic clock, rst_b, cfg_wr, cfg_rd, chk3, div_prev;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, rd_val, d;
    logic [3:0] src_sel, div_in, ref_out;
    logic [5:0] pump_code;
    logic [10:0] pump_ua;
    logic pol, hold, mid, byp, spd, busy;
    int err_total, cmp_count, cyc;
    int mdl [int];
    int ratios [10] = '{64, 96, 128, 192, 256, 384, 512, 768, 1024, 2048};
    vps_host host_u (.clock(clock), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
    vps_vcxo_sysref_ctrl #(.NUM_REF(4)) dut_u (.clock(clock), .rst_b(rst_b), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .reference_source_select(src_sel), .clock_div_in(div_in), .reference_output(ref_out),
        .pump_current_code(pump_code), .pump_current_ua(pump_ua), .vcxo_polarity_select(pol),
        .holdover(hold), .vcxo_mid_supply(mid), .vcxo_bypass(byp),
        .synchronizer_power_down(spd), .burst_active(busy));
    // ********************
    // clock, checks, model
    // ********************
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        div_prev = div_in[3];
        div_in <= 4'($urandom);
        cyc++;
        if (cyc == 50000) begin
            err_total++;
            print_verdict();
        end
    end
    always @(negedge clock) if (chk3) check("ref_out3", ref_out[3], div_prev);
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic mwr(input logic [7:0] a, input logic [7:0] v);
        host_u.wr(a, v);
        if (mdl.exists(a)) mdl[a] = (a == 8'h10) ? ((v & 8'hf0) | 8'h04) : v;
        repeat (2) @(posedge clock);
        #1;
    endtask : mwr
    task automatic mrd(input logic [7:0] a);
        host_u.rd(a, rd_val);
        check("rdata", rd_val, mdl.exists(a) ? 16'(mdl[a]) : 16'h0000);
    endtask : mrd
    task automatic burst(input int n, input int ratio);
        int cnt [3];
        int first;
        int last;
        cnt = '{0, 0, 0};
        first = -1;
        host_u.burst(8'(n));
        mdl[3] = mdl[3] & 8'hfe;
        mdl[23] = n;
        for (int t = 0; t < n * ratio + ratio + 40; t++) begin
            @(negedge clock);
            for (int k = 0; k < 3; k++) cnt[k] += ref_out[k];
            if (t == 2) check("busy", busy, 1);
            check("ref_out1", ref_out[1], ref_out[0]);
            if (ref_out[0] === 1'b1) begin
                if (first >= 0) check("spacing", 16'(t - last), 16'(ratio));
                else first = t;
                last = t;
            end
        end
        check("count0", 16'(cnt[0]), 16'(n));
        check("count1", 16'(cnt[1]), 16'(n));
        check("count2", 16'(cnt[2]), 16'h0000);
        check("sync_wait", 16'(first >= 10), 16'h0001);
        check("idle", busy, 0);
    endtask : burst
    // ********************
    // main sequence
    // ********************
    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        chk3 = 1'b0;
        src_sel = 4'b0111;
        div_in = 4'h0;
        mdl = '{3: 8'h00, 7: 8'h04, 11: 8'h4f, 13: 8'h20, 16: 8'h04, 23: 8'h00};
        void'($urandom(10567));
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk3 = 1'b1;
        check("pump_code", pump_code, 16'h0020);
        check("pump_ua", pump_ua, 16'd640);
        check("outs", {pol, hold, mid, byp, spd, busy}, 16'h0000);
        foreach (mdl[a]) mrd(8'(a));
        mrd(8'h55);
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'h3f : (i == 1) ? 8'hc0 : 8'($urandom);
            mwr(8'h0d, d);
            check("pump_code", pump_code, 16'(d[5:0]));
            check("pump_ua", pump_ua, 16'(d[5:0] * 20));
            check("pol", pol, d[7]);
            check("hold", {hold, mid}, {2{d[6]}});
            mrd(8'h0d);
        end
        mwr(8'h10, 8'hff);
        check("bypass", byp, 1);
        mrd(8'h10);
        mwr(8'h10, 8'h00);
        check("bypass", byp, 0);
        mwr(8'h07, 8'h24);
        check("sync_pd", spd, 1);
        mwr(8'h17, 8'h04);
        check("launch_pd", busy, 0);
        mwr(8'h07, 8'h04);
        check("sync_pd", spd, 0);
        for (int sel = 0; sel < 10; sel++) begin
            mwr(8'h0b, {4'(sel), 4'hb});
            burst((sel == 0) ? 255 : (sel < 4) ? sel + 1 : 1, ratios[sel]);
        end
        mwr(8'h03, 8'h01);
        mwr(8'h17, 8'h05);
        check("launch_mode", busy, 0);
        mwr(8'h03, 8'h00);
        mwr(8'h17, 8'h00);
        check("launch_zero", busy, 0);
        mrd(8'h17);
        print_verdict();
    end
endmodule : vcxo_pll_and_sysref_control_tb_top
